// *** logic/local_memory_io_controller.sv ***
`timescale 1ns/100ps
module local_memory_io_controller
   import lmc_pkg::*;
#(
   parameter int BurstMax = 4
)
(
   // clock and reset
   input  wire logic                  mclk,
   input  wire logic                  rst,
   // core request side
   input  wire logic                  reqValid,
   output logic                       reqReady,
   input  wire logic [31:0]           reqAddr,
   input  wire logic                  reqWrite,
   input  wire logic [3:0]            reqByteEn,
   input  wire logic [31:0]           reqWrData,
   input  wire logic [2:0]            reqBeats,
   input  wire logic                  reqSubBlock,
   output logic                       rdValid,
   output logic      [31:0]           rdData,
   output logic                       reqDone,
   // per-bank configuration
   input  wire logic [2*NumCs-1:0]    bankWidth,
   input  wire logic [2*NumCs-1:0]    bankMode,
   input  wire logic [4*NumCs-1:0]    bankWaits,
   input  wire logic [31:0]           win4Base,
   input  wire logic [31:0]           win4Mask,
   input  wire logic [31:0]           win5Base,
   input  wire logic [31:0]           win5Mask,
   // status
   output logic                       busy,
   output logic      [7:0]            restartCount,
   // memory pins
   output logic      [AddrHi:2]       memAddr,
   input  wire logic [31:0]           memDataIn,
   output logic      [31:0]           memDataOut,
   output logic                       memDataOe,
   output logic      [NumCs-1:0]      chipSelLow,
   output logic                       memOutEnLow,
   output logic      [3:0]            writeEnLow,
   input  wire logic                  memWaitLow,
   output logic                       bufferEnLow,
   output logic                       buffer_direction_low
);
   lmc_state_type stateReg;
   logic [NumCs-1:0] hit;
   logic [NumCs-1:0] bankReg;
   logic [2:0]       bankIdx;
   logic [31:0]      addrReg;
   logic [31:0]      baseReg;
   logic             writeReg;
   logic [3:0]       byteEnReg;
   logic [2:0]       beatsReg;
   logic [2:0]       beatReg;
   logic             subBlockReg;
   logic [3:0]       waitReg;
   logic             waitSync1;
   logic             waitSync2;
   logic [1:0]       widthSel;
   logic [1:0]       modeSel;
   logic [3:0]       waitsSel;
   logic             strobeWe;

   // pin input synchroniser, second stage only is read
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         waitSync1 <= 1'b1;
         waitSync2 <= 1'b1;
      end
      else
      begin
         waitSync1 <= memWaitLow;
         waitSync2 <= waitSync1;
      end
   end

   lmc_decode u_decode
   (
      .addr     (reqAddr),
      .win4Base (win4Base),
      .win4Mask (win4Mask),
      .win5Base (win5Base),
      .win5Mask (win5Mask),
      .hit      (hit)
   );

   always_comb
   begin
      bankIdx = 3'h0;
      for (int k = 0; k < NumCs; k++)
      begin
         if (bankReg[k])
         begin
            bankIdx = 3'(k);
         end
      end
   end

   assign widthSel = bankWidth[2*bankIdx +: 2];
   assign modeSel  = bankMode[2*bankIdx +: 2];
   assign waitsSel = bankWaits[4*bankIdx +: 4];

   assign reqReady = (stateReg == StIdle) && (|hit);
   assign busy     = (stateReg != StIdle);

   // sequencing: setup, strobe with wait count, hold, next beat
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         stateReg <= StIdle;
      end
      else
      begin
         unique case (stateReg)
            StIdle:
               if (reqValid && reqReady)
               begin
                  stateReg <= StSetup;
               end
            StSetup:
               stateReg <= StStrobe;
            StStrobe:
               if (modeSel == ModeDual && !waitSync2)
               begin
                  stateReg <= StSetup;
               end
               else if (waitReg == 4'h0 && waitSync2)
               begin
                  stateReg <= StHold;
               end
            StHold:
               if (beatReg == beatsReg)
               begin
                  stateReg <= StDone;
               end
               else
               begin
                  stateReg <= StSetup;
               end
            StDone:
               stateReg <= StIdle;
         endcase
      end
   end

   // automatic wait states, reloaded per strobe
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         waitReg <= WaitReset;
      end
      else if (stateReg == StSetup)
      begin
         waitReg <= waitsSel;
      end
      else if (stateReg == StStrobe && waitReg != 4'h0)
      begin
         waitReg <= waitReg - 4'h1;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         restartCount <= 8'h00;
      end
      else if (stateReg == StStrobe && modeSel == ModeDual && !waitSync2)
      begin
         restartCount <= restartCount + 8'h01;
      end
   end

   // request capture and address stepping
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         bankReg     <= '0;
         addrReg     <= '0;
         baseReg     <= '0;
         writeReg    <= 1'b0;
         byteEnReg   <= 4'h0;
         beatsReg    <= BurstReset;
         beatReg     <= BurstReset;
         subBlockReg <= 1'b0;
         memDataOut  <= '0;
      end
      else if (stateReg == StIdle && reqValid && reqReady)
      begin
         bankReg     <= hit;
         addrReg     <= reqAddr;
         baseReg     <= reqAddr;
         writeReg    <= reqWrite;
         byteEnReg   <= reqByteEn;
         beatsReg    <= (reqBeats >= 3'(BurstMax)) ?
                        3'(BurstMax - 1) : reqBeats;
         beatReg     <= BurstReset;
         subBlockReg <= reqSubBlock;
         memDataOut  <= reqWrData;
      end
      else if (stateReg == StHold && beatReg != beatsReg)
      begin
         beatReg <= beatReg + 3'h1;
         if (subBlockReg)
         begin
            // sub-block: flip word index bits, critical word first
            addrReg[3:2] <= baseReg[3:2] ^ 2'(beatReg + 3'h1);
         end
         else
         begin
            addrReg[23:2] <= addrReg[23:2] + 22'h1;
         end
      end
   end

   // read data capture at end of strobe
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         rdValid <= 1'b0;
         rdData  <= '0;
      end
      else
      begin
         rdValid <= 1'b0;
         if (stateReg == StHold && !writeReg)
         begin
            rdValid <= 1'b1;
            rdData  <= memDataIn;
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         reqDone <= 1'b0;
      end
      else
      begin
         reqDone <= (stateReg == StHold) && (beatReg == beatsReg);
      end
   end

   // pin drivers, registered
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         memAddr              <= '0;
         chipSelLow           <= CsIdle;
         memOutEnLow          <= 1'b1;
         bufferEnLow          <= 1'b1;
         buffer_direction_low <= 1'b1;
         memDataOe            <= 1'b0;
      end
      else
      begin
         memAddr <= addrReg[AddrHi:2];
         if (stateReg == StSetup || stateReg == StStrobe)
         begin
            chipSelLow           <= ~bankReg;
            memOutEnLow          <= writeReg;
            bufferEnLow          <= 1'b0;
            buffer_direction_low <= writeReg;
            memDataOe            <= writeReg;
         end
         else
         begin
            chipSelLow           <= CsIdle;
            memOutEnLow          <= 1'b1;
            bufferEnLow          <= 1'b1;
            buffer_direction_low <= 1'b1;
            memDataOe            <= 1'b0;
         end
      end
   end

   // write strobe from setup through the last wait, zero waits still strobe
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         strobeWe <= 1'b0;
      end
      else
      begin
         strobeWe <= writeReg
                     && (stateReg == StSetup
                         || (stateReg == StStrobe
                             && !(waitReg == 4'h0 && waitSync2)));
      end
   end

   lmc_lanes u_lanes
   (
      .width    (widthSel),
      .byteAddr (addrReg[1:0]),
      .byteEn   (byteEnReg),
      .strobe   (strobeWe),
      .weLow    (writeEnLow)
   );
endmodule : local_memory_io_controller

// *** pkg/lmc_pkg.sv ***
package lmc_pkg;
   localparam int NumCs        = 6;
   localparam int AddrHi       = 22;
   localparam int WordAddrBits = 21;
   localparam int BankSelLo    = 23;
   localparam logic [1:0] WidthBits8  = 2'h0;
   localparam logic [1:0] WidthBits16 = 2'h1;
   localparam logic [1:0] WidthBits32 = 2'h2;
   localparam logic [1:0] ModeSram    = 2'h0;
   localparam logic [1:0] ModeIoA     = 2'h1;
   localparam logic [1:0] ModeIoB     = 2'h2;
   localparam logic [1:0] ModeDual    = 2'h3;
   localparam logic [3:0] WaitReset   = 4'h2;
   localparam logic [NumCs-1:0] CsIdle = 6'h3f;
   localparam logic [3:0] WeIdle      = 4'hf;
   localparam logic [2:0] BurstReset  = 3'h0;

   typedef enum logic [4:0]
   {
      StIdle   = 5'b00001,
      StSetup  = 5'b00010,
      StStrobe = 5'b00100,
      StHold   = 5'b01000,
      StDone   = 5'b10000
   } lmc_state_type;
endpackage : lmc_pkg

// *** logic/lmc_decode.sv ***
`timescale 1ns/100ps
module lmc_decode
   import lmc_pkg::*;
(
   // access address, byte granular
   input  wire logic [31:0]      addr,
   // programmable windows for chip selects 4 and 5
   input  wire logic [31:0]      win4Base,
   input  wire logic [31:0]      win4Mask,
   input  wire logic [31:0]      win5Base,
   input  wire logic [31:0]      win5Mask,
   // one-hot hit, active high
   output logic      [NumCs-1:0] hit
);
   // fixed banks sit at consecutive 8MB slots above bit 23
   genvar i;
   generate
      for (i = 0; i < NumCs - 2; i++)
      begin : g_fixed
         assign hit[i] = (addr[31:BankSelLo] == 9'(i));
      end
   endgenerate

   // window hits only if no fixed bank claimed the address, keeps one-hot
   logic anyFixed;
   assign anyFixed = |hit[NumCs-3:0];
   assign hit[4] = !anyFixed && ((addr & win4Mask) == win4Base);
   assign hit[5] = !anyFixed && !hit[4]
                   && ((addr & win5Mask) == win5Base);
endmodule : lmc_decode

// *** logic/lmc_lanes.sv ***
`timescale 1ns/100ps
module lmc_lanes
   import lmc_pkg::*;
(
   // port width and byte address bits
   input  wire logic [1:0] width,
   input  wire logic [1:0] byteAddr,
   // byte enables of the request, active high
   input  wire logic [3:0] byteEn,
   // write strobe phase
   input  wire logic       strobe,
   // active low enables toward the pins in 32 bit width, bit 2 carries address in 16 bit width, bits 2:1 in 8 bit width
   output logic      [3:0] weLow
);
   always_comb
   begin
      weLow = WeIdle;
      unique case (width)
         WidthBits32: weLow = ~(byteEn & {4{strobe}});
         WidthBits16:
         begin
            weLow[3] = ~(strobe && (byteEn[1] || byteEn[3]));
            weLow[2] = byteAddr[1];
            weLow[1] = 1'b0;
            weLow[0] = ~(strobe && (byteEn[0] || byteEn[2]));
         end
         default:
         begin
            weLow[3] = 1'b1;
            weLow[2] = byteAddr[1];
            weLow[1] = byteAddr[0];
            weLow[0] = ~(strobe && (|byteEn));
         end
      endcase
   end
endmodule : lmc_lanes

// *** dv/lmc_properties.sv ***
`timescale 1ns/100ps
module lmc_checker
   import lmc_pkg::*;
(
   // clock and reset
   input wire logic             mclk,
   input wire logic             rst,
   // core side
   input wire logic             reqValid,
   input wire logic             reqReady,
   input wire logic             reqDone,
   input wire logic             busy,
   input wire logic [7:0]       restartCount,
   // pins
   input wire logic [NumCs-1:0] chipSelLow,
   input wire logic             memOutEnLow,
   input wire logic [3:0]       writeEnLow,
   input wire logic             bufferEnLow,
   input wire logic             buffer_direction_low
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   logic sel;
   assign sel = chipSelLow != CsIdle;
   property p_one_cs;
      $onehot0(~chipSelLow);
   endproperty
   a_one_cs: assert property (p_one_cs)
      else $error("more than one select low");
   property p_oe_read;
      !memOutEnLow |-> sel && !buffer_direction_low && writeEnLow[0];
   endproperty
   a_oe_read: assert property (p_oe_read)
      else $error("output enable outside a selected read");
   property p_buf_en;
      sel |-> !bufferEnLow;
   endproperty
   a_buf_en: assert property (p_buf_en)
      else $error("transceiver off during access");
   property p_dir_write;
      !writeEnLow[0] |-> buffer_direction_low && memOutEnLow && sel;
   endproperty
   a_dir_write: assert property (p_dir_write)
      else $error("write strobe with read direction");
   property p_reset_idle;
      $fell(rst) |-> chipSelLow == CsIdle && memOutEnLow
         && writeEnLow == WeIdle && bufferEnLow;
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("pins not idle after reset");
   property p_take_pins;
      reqValid && reqReady |-> ##1 busy ##1 sel;
   endproperty
   a_take_pins: assert property (p_take_pins)
      else $error("no select two cycles after take");
   property p_busy_ready;
      busy |-> !reqReady;
   endproperty
   a_busy_ready: assert property (p_busy_ready)
      else $error("ready while busy");
   property p_done_pulse;
      reqDone |=> !reqDone;
   endproperty
   a_done_pulse: assert property (p_done_pulse)
      else $error("done longer than one cycle");
   property p_restart_step;
      restartCount != $past(restartCount)
         |-> restartCount == $past(restartCount) + 8'h01;
   endproperty
   a_restart_step: assert property (p_restart_step)
      else $error("restart count jumped");
endmodule : lmc_checker

bind local_memory_io_controller lmc_checker lmc_checker_i (
   .mclk(mclk), .rst(rst), .reqValid(reqValid), .reqReady(reqReady),
   .reqDone(reqDone), .busy(busy), .restartCount(restartCount),
   .chipSelLow(chipSelLow), .memOutEnLow(memOutEnLow),
   .writeEnLow(writeEnLow), .bufferEnLow(bufferEnLow),
   .buffer_direction_low(buffer_direction_low));

// *** dv/lmc_mem_model.sv ***
`timescale 1ns/100ps
module lmc_mem_model
   import lmc_pkg::*;
(
   // clock
   input wire logic             mclk,
   // memory pins
   input wire logic [NumCs-1:0] chipSelLow,
   input wire logic             memOutEnLow,
   input wire logic [AddrHi:2]  memAddr,
   output logic     [31:0]      memDataIn,
   output logic                 memWaitLow,
   // bench command: stall or busy
   input wire logic             stall
);
   logic [31:0] lastData = 32'h0;
   logic        held = 1'b0;
   logic        rdSel;
   assign rdSel = !memOutEnLow && chipSelLow != CsIdle;
   always_ff @(posedge mclk)
   begin
      if (rdSel)
         lastData <= memDataIn;
      held <= rdSel;
   end
   // one cycle of hold, then stale inverted data so no false match
   assign memDataIn = rdSel ? {11'h5a3, memAddr} :
                      held ? lastData : ~lastData;
   // pulled up unless stalling a selected access
   assign memWaitLow = !(stall && chipSelLow != CsIdle);
endmodule : lmc_mem_model

// *** dv/local_memory_io_controller_tb_top.sv ***
`timescale 1ns/100ps
module local_memory_io_controller_tb_top
   import lmc_pkg::*;
;
   logic mclk = 0, rst = 1, reqValid = 0, reqWrite = 0, reqSubBlock = 0;
   logic stall = 0;
   logic [31:0] reqAddr = 0, reqWrData = 0, rdData, memDataIn;
   logic [31:0] win4Base = 32'hf000_0000, win5Base = 32'he000_0000;
   logic [31:0] win4Mask = 32'hff80_0000, win5Mask = 32'hff80_0000;
   logic [3:0] reqByteEn = 0, writeEnLow;
   logic [2:0] reqBeats = 0;
   logic [11:0] bankWidth = {WidthBits32, WidthBits32, WidthBits32,
                             WidthBits8, WidthBits16, WidthBits32};
   logic [11:0] bankMode = {ModeIoB, ModeIoA, ModeDual,
                            ModeSram, ModeSram, ModeSram};
   logic [23:0] bankWaits = 0;
   logic [7:0] restartCount, rc0;
   logic [AddrHi:2] memAddr;
   logic [NumCs-1:0] chipSelLow;
   logic reqReady, rdValid, reqDone, busy, memOutEnLow, memWaitLow;
   logic bufferEnLow, buffer_direction_low;
   logic [31:0] rdQ[$];
   logic [3:0] weQ[$];
   logic [31:0] wdQ[$];
   logic [NumCs-1:0] csQ[$];
   logic [31:0] memDataOut;
   logic memDataOe;
   int n_errors = 0, tests_run = 0;
   always #4 mclk = ~mclk;
   local_memory_io_controller #(.BurstMax(4)) local_memory_io_controller_i
      (.mclk, .rst, .reqValid, .reqReady, .reqAddr, .reqWrite, .reqByteEn,
       .reqWrData, .reqBeats, .reqSubBlock, .rdValid, .rdData, .reqDone,
       .bankWidth, .bankMode, .bankWaits, .win4Base, .win4Mask, .win5Base,
       .win5Mask, .busy, .restartCount, .memAddr, .memDataIn,
       .memDataOut, .memDataOe, .chipSelLow, .memOutEnLow, .writeEnLow,
       .memWaitLow, .bufferEnLow, .buffer_direction_low);
   lmc_mem_model lmc_mem_model_i (.mclk, .chipSelLow, .memOutEnLow,
      .memAddr, .memDataIn, .memWaitLow, .stall);
   task cmpData(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %0t data %h exp %h", $time, got, exp);
      end
   endtask : cmpData
   task cmpBits(input logic [3:0] got, input logic [3:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %0t bits %b exp %b", $time, got, exp);
      end
   endtask : cmpBits
   function logic [3:0] lanes(input logic [1:0] w, input logic [1:0] ba,
                              input logic [3:0] be);
      if (w == WidthBits32) return ~be;
      if (w == WidthBits16) return {1'b0, ba[1], 2'b00};
      return {1'b1, ba[1], ba[0], 1'b0};
   endfunction : lanes
   task req(input logic [31:0] a, input logic w, input logic [3:0] be,
            input logic [2:0] nb, input logic sb);
      logic [31:0] ea;
      logic [NumCs-1:0] cs;
      logic got;
      for (int i = 0; i <= int'(nb) && !w; i++)
      begin
         ea = sb ? {a[31:4], a[3:2] ^ 2'(i), 2'h0} : a + 32'(4 * i);
         rdQ.push_back({11'h5a3, ea[22:2]});
      end
      // fixed slots first, then the two windows
      cs = (a[31:BankSelLo] < 9'h4) ? 6'h01 << a[31:BankSelLo] :
           ((a & win4Mask) == win4Base) ? 6'h10 : 6'h20;
      csQ.push_back(~cs);
      reqAddr = a;
      reqWrite = w;
      reqByteEn = be;
      reqBeats = nb;
      reqSubBlock = sb;
      reqWrData = $urandom;
      if (w)
         wdQ.push_back(reqWrData);
      reqValid = 1;
      got = 0;
      repeat (100)
      begin
         @(posedge mclk);
         if (reqReady === 1'b1)
         begin
            got = 1;
            break;
         end
      end
      #1 reqValid = 0;
      cmpBits({3'h0, got}, 4'h1);
   endtask : req
   task waitDone();
      logic got;
      got = 0;
      repeat (300)
      begin
         @(posedge mclk);
         if (reqDone === 1'b1)
         begin
            got = 1;
            break;
         end
      end
      #1 cmpBits({3'h0, got}, 4'h1);
   endtask : waitDone
   task wrap_up();
      $display("errors %0d compares %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : wrap_up
   always @(posedge mclk)
   begin
      if (rdValid === 1'b1)
         cmpData(rdData, rdQ.size() ? rdQ.pop_front() : 32'hx);
      if (writeEnLow[0] === 1'b0 && weQ.size() != 0)
      begin
         cmpBits(writeEnLow, weQ[0]);
         cmpData(memDataOut, wdQ[0]);
         cmpBits({bufferEnLow, buffer_direction_low, memOutEnLow,
                  memDataOe}, 4'h7);
      end
      if (memOutEnLow === 1'b0)
         cmpBits({1'b0, bufferEnLow, buffer_direction_low, memDataOe},
                 4'h0);
      if (chipSelLow !== CsIdle && csQ.size() != 0)
         cmpData(32'(chipSelLow), 32'(csQ[0]));
      if (reqDone === 1'b1 && weQ.size() != 0)
         weQ.delete(0);
      if (reqDone === 1'b1 && wdQ.size() != 0)
         wdQ.delete(0);
      if (reqDone === 1'b1 && csQ.size() != 0)
         csQ.delete(0);
   end
   initial
   begin
      #200000;
      n_errors++;
      wrap_up();
   end
   initial
   begin
      logic [31:0] a;
      logic [3:0] be;
      logic [1:0] w;
      void'($urandom(46334));
      // at least two waits, so the synced wait input is seen in time
      bankWaits = 24'($urandom) | 24'h222222;
      repeat (12) @(posedge mclk);
      #1 rst = 0;
      cmpBits({bufferEnLow, memOutEnLow, reqDone, rdValid}, 4'hc);
      cmpData(32'(chipSelLow), 32'(CsIdle));
      reqAddr = 32'h0200_0000;
      reqValid = 1;
      @(posedge mclk);
      #1 cmpBits({3'h0, reqReady}, 4'h0);
      reqValid = 0;
      for (int k = 0; k < 6; k++)
      begin
         a = {7'h0, 2'(k % 3), 23'($urandom)};
         w = bankWidth[2 * (k % 3) +: 2];
         be = (w == WidthBits32) ? (4'($urandom) | 4'h1) :
              (w == WidthBits16) ? (a[1] ? 4'hc : 4'h3) : 4'h1 << a[1:0];
         weQ.push_back(lanes(w, a[1:0], be));
         req(a, 1'b1, be, 3'h0, 1'b0);
         waitDone();
      end
      req(32'h007f_fff0, 1'b0, 4'hf, 3'h3, 1'b0);
      waitDone();
      req(32'h0000_0128, 1'b0, 4'hf, 3'h3, 1'b1);
      waitDone();
      for (int j = 0; j < 2; j++)
      begin
         rc0 = restartCount;
         stall = 1;
         req(j ? 32'h0180_0020 : 32'h007f_fffc, 1'b0, 4'hf, 3'h0, 1'b0);
         repeat (6) @(posedge mclk);
         #1 stall = 0;
         waitDone();
         cmpBits({3'h0, restartCount !== rc0}, 4'(j));
      end
      for (int j = 0; j < 2; j++)
      begin
         a = j ? 32'he000_0020 : 32'hf000_0010;
         req(a, 1'b0, 4'hf, 3'h1, 1'b0);
         waitDone();
      end
      cmpData(32'(rdQ.size()), 32'h0);
      wrap_up();
   end
endmodule : local_memory_io_controller_tb_top
